// ---- rtl/pin_func_mux.sv ----
/*
 * pin function multiplexer for ports s, p, j and l.
 * assumes peripheral requests, routing bits and pins are synchronous to core_clk_i;
 * pin outputs and function inputs are registered one cycle.
 */
// How it works
// - s7 order timer0, cap1, sent, select, gpio
// - routed channel 1 only captures on s7
// - capture 1 to 3 take alternative sources
// - s5 timer2, uart_b transmit, mosi, gpio
// - s4 timer3, uart_b receive, miso, gpio
// - s3 nmi, can or direct, select, gpio
// - nmi armed on first clear, pin input
// - no nmi wakeup while mask set
// - s2 irq, can receive, spi clock, gpio
// - s1 phy transmit, uart, i2c, mosi, gpio
// - s0 phy receive, uart, i2c, miso, gpio
// - p7 to p4 fast pwm over gpio
// - low-side pins raise over-current interrupt
// - p2 high-side pwm with over-current interrupt
// - routed adc trigger outranks pwm on p4
// - port l high-voltage inputs only
// - everything falls back to gpio at reset
module pin_func_mux
	import pin_mux_pkg::*;
(
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       srst_i,
	// package pins
	input  wire logic [7:0] port_s_pin_i,
	output logic      [7:0] port_s_pin_o,
	output logic      [7:0] port_s_pin_oe_o,
	input  wire logic [7:0] port_p_pin_i,
	output logic      [7:0] port_p_pin_o,
	output logic      [7:0] port_p_pin_oe_o,
	input  wire logic [1:0] port_j_pin_i,
	output logic      [1:0] port_j_pin_o,
	output logic      [1:0] port_j_pin_oe_o,
	input  wire logic [1:0] port_l_pin_i,
	// routing
	input  wire logic       timer_a_cap1_route_bit_i,
	input  wire logic       timer_a_cap2_route_bit_i,
	input  wire logic [1:0] timer_a_cap3_route_field_i,
	input  wire logic       uart_a_route_bit_i,
	input  wire logic       uart_b_route_bit_i,
	input  wire logic       i2c_route_bit_i,
	input  wire logic       spi_a_route_bit_i,
	input  wire logic [2:0] can_route_field_i,
	input  wire logic [1:0] adc_trigger_route_field_i,
	input  wire logic       pwm_a_ch7_route_bit_i,
	input  wire logic       pwm_a_ch3_route_bit_i,
	// timer, channels 0 to 3
	input  wire logic [3:0] timer_a_en_i,
	input  wire logic [3:0] timer_a_out_i,
	input  wire logic [3:0] timer_a_oe_i,
	input  wire logic       timer_a_cap2_alt_i,
	output logic      [3:0] timer_a_in_o,
	// sent line
	input  wire logic       sent_line_en_i,
	input  wire logic       sent_line_out_i,
	input  wire logic       sent_line_oe_i,
	output logic            sent_line_in_o,
	// spi, lanes select, clock, master out, master in
	input  wire logic [3:0] spi_a_en_i,
	input  wire logic [3:0] spi_a_out_i,
	input  wire logic [3:0] spi_a_oe_i,
	output logic      [3:0] spi_a_in_o,
	input  wire logic [3:0] spi_b_en_i,
	input  wire logic [3:0] spi_b_out_i,
	input  wire logic [3:0] spi_b_oe_i,
	output logic      [3:0] spi_b_in_o,
	// uart, lanes transmit, receive
	input  wire logic [1:0] uart_a_en_i,
	input  wire logic       uart_a_out_i,
	input  wire logic       uart_a_oe_i,
	output logic      [1:0] uart_a_in_o,
	input  wire logic [1:0] uart_b_en_i,
	input  wire logic       uart_b_out_i,
	input  wire logic       uart_b_oe_i,
	output logic      [1:0] uart_b_in_o,
	// i2c, lanes clock line, data line
	input  wire logic [1:0] i2c_en_i,
	input  wire logic [1:0] i2c_out_i,
	input  wire logic [1:0] i2c_oe_i,
	output logic      [1:0] i2c_in_o,
	// interrupts
	input  wire logic       x_mask_i,
	input  wire logic       stop_wait_i,
	input  wire logic       irq_en_i,
	output logic            nonmaskable_interrupt_in_o,
	output logic            nmi_enabled_o,
	output logic            nmi_wake_o,
	output logic            irq_in_o,
	// can and can phy
	input  wire logic       can_en_i,
	input  wire logic       can_transmit_i,
	input  wire logic       can_phy_direct_out_i,
	input  wire logic       can_phy_receive_out_i,
	output logic            can_receive_o,
	output logic            can_phy_transmit_in_o,
	// pwm, channels 7, 5, 3, 1
	input  wire logic [3:0] pwm_a_en_i,
	input  wire logic [3:0] pwm_a_out_i,
	input  wire logic [3:0] pwm_b_en_i,
	input  wire logic [3:0] pwm_b_out_i,
	output logic            adc_external_trigger_o,
	// general port bits
	input  wire logic [7:0] port_s_data_out_i,
	input  wire logic [7:0] port_s_data_oe_i,
	output logic      [7:0] port_s_data_o,
	output logic      [7:0] port_s_key_wakeup_o,
	input  wire logic [7:0] port_p_data_out_i,
	input  wire logic [7:0] port_p_data_oe_i,
	output logic      [7:0] port_p_data_o,
	output logic      [7:0] port_p_key_wakeup_o,
	input  wire logic [7:0] port_p_oc_sense_i,
	output logic      [7:0] port_p_oc_irq_o,
	input  wire logic [1:0] port_j_data_out_i,
	input  wire logic [1:0] port_j_data_oe_i,
	output logic      [1:0] port_j_data_o,
	// high voltage inputs
	input  wire logic [1:0] port_l_adc_link_en_i,
	output logic      [1:0] port_l_input_o,
	output logic      [1:0] port_l_key_wakeup_o,
	output logic      [1:0] port_l_adc_link_o
);
	// ****************
	// request table
	// ****************
	logic [NUM_PINS-1:0][NUM_SLOTS-1:0] req_w;
	logic [NUM_PINS-1:0][NUM_SLOTS-1:0] out_w;
	logic [NUM_PINS-1:0][NUM_SLOTS-1:0] oe_w;
	logic [NUM_PINS-1:0][NUM_SLOTS-1:0] gnt_w;
	logic [NUM_PINS-1:0]                pin_in_w;
	logic [NUM_PINS-1:0]                pin_out_w;
	logic [NUM_PINS-1:0]                pin_oe_w;
	logic                               nmi_armed_w;
	logic                               can_main_w;

	assign pin_in_w   = {port_j_pin_i, port_p_pin_i, port_s_pin_i};
	assign can_main_w = can_en_i && (can_route_field_i == CAN_RT_CAN);

	function automatic logic samp(input logic g, input logic p);
		return g ? p : IDLE_LVL;
	endfunction

	always_comb
	begin
		req_w = '0;
		out_w = '0;
		oe_w  = '0;
		for (int i = 0; i < NUM_PINS; i++)
			req_w[i][SLOT_GPIO] = 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			out_w[PIN_S0+i][SLOT_GPIO] = port_s_data_out_i[i];
			oe_w[PIN_S0+i][SLOT_GPIO]  = port_s_data_oe_i[i];
			out_w[PIN_P0+i][SLOT_GPIO] = port_p_data_out_i[i];
			oe_w[PIN_P0+i][SLOT_GPIO]  = port_p_data_oe_i[i];
		end
		for (int i = 0; i < 2; i++)
		begin
			out_w[PIN_J0+i][SLOT_GPIO] = port_j_data_out_i[i];
			oe_w[PIN_J0+i][SLOT_GPIO]  = port_j_data_oe_i[i];
		end
		// s7: timer ch0, routed capture 1 (input only), sent, spi_b select
		// capture slot only while channel 1 runs, else gpio would lose s7 out of reset
		req_w[PIN_S0+7][3:0] = {spi_b_en_i[0], sent_line_en_i,
			timer_a_en_i[1] && !timer_a_cap1_route_bit_i, timer_a_en_i[0]};
		out_w[PIN_S0+7][3:0] = {spi_b_out_i[0], sent_line_out_i, 1'b0, timer_a_out_i[0]};
		oe_w[PIN_S0+7][3:0]  = {spi_b_oe_i[0], sent_line_oe_i, 1'b0, timer_a_oe_i[0]};
		// s6: compare of ch1 stays here whatever the capture routing
		req_w[PIN_S0+6][1:0] = {spi_b_en_i[1], timer_a_en_i[1]};
		out_w[PIN_S0+6][1:0] = {spi_b_out_i[1], timer_a_out_i[1]};
		oe_w[PIN_S0+6][1:0]  = {spi_b_oe_i[1], timer_a_oe_i[1]};
		req_w[PIN_S0+5][2:0] = {spi_b_en_i[2], uart_b_en_i[0] && !uart_b_route_bit_i, timer_a_en_i[2]};
		out_w[PIN_S0+5][2:0] = {spi_b_out_i[2], uart_b_out_i, timer_a_out_i[2]};
		oe_w[PIN_S0+5][2:0]  = {spi_b_oe_i[2], uart_b_oe_i, timer_a_oe_i[2]};
		req_w[PIN_S0+4][2:0] = {spi_b_en_i[3], uart_b_en_i[1] && !uart_b_route_bit_i, timer_a_en_i[3]};
		out_w[PIN_S0+4][2:0] = {spi_b_out_i[3], 1'b0, timer_a_out_i[3]};
		oe_w[PIN_S0+4][2:0]  = {spi_b_oe_i[3], 1'b0, timer_a_oe_i[3]};
		// s3: armed nmi forces the pin to input
		req_w[PIN_S0+3][2:0] = {spi_a_en_i[0] && !spi_a_route_bit_i,
			can_main_w || (can_route_field_i == CAN_RT_DIRECT), nmi_armed_w};
		out_w[PIN_S0+3][2:1] = {spi_a_out_i[0], can_main_w ? can_transmit_i : can_phy_direct_out_i};
		oe_w[PIN_S0+3][2:1]  = {spi_a_oe_i[0], 1'b1};
		req_w[PIN_S0+2][2:0] = {spi_a_en_i[1] && !spi_a_route_bit_i, can_main_w, irq_en_i};
		out_w[PIN_S0+2][2]   = spi_a_out_i[1];
		oe_w[PIN_S0+2][2]    = spi_a_oe_i[1];
		req_w[PIN_S0+1][3:0] = {spi_a_en_i[2] && !spi_a_route_bit_i, i2c_en_i[0] && i2c_route_bit_i,
			uart_a_en_i[0] && uart_a_route_bit_i, can_route_field_i == CAN_RT_PHY};
		out_w[PIN_S0+1][3:1] = {spi_a_out_i[2], i2c_out_i[0], uart_a_out_i};
		oe_w[PIN_S0+1][3:1]  = {spi_a_oe_i[2], i2c_oe_i[0], uart_a_oe_i};
		req_w[PIN_S0+0][3:0] = {spi_a_en_i[3] && !spi_a_route_bit_i, i2c_en_i[1] && i2c_route_bit_i,
			uart_a_en_i[1] && uart_a_route_bit_i, can_route_field_i == CAN_RT_PHY};
		out_w[PIN_S0+0][3:0] = {spi_a_out_i[3], i2c_out_i[1], 1'b0, can_phy_receive_out_i};
		oe_w[PIN_S0+0][3:0]  = {spi_a_oe_i[3], i2c_oe_i[1], 1'b0, 1'b1};
		// p7..p4 fast pwm, p3..p0 pwm with two routed channels
		for (int i = 0; i < 4; i++)
		begin
			req_w[PIN_P0+7-i][1] = pwm_b_en_i[i];
			out_w[PIN_P0+7-i][1] = pwm_b_out_i[i];
			oe_w[PIN_P0+7-i][1]  = 1'b1;
			out_w[PIN_P0+3-i][1] = pwm_a_out_i[i];
			oe_w[PIN_P0+3-i][1]  = 1'b1;
		end
		req_w[PIN_P0+3][1] = pwm_a_en_i[0] && !pwm_a_ch7_route_bit_i;
		req_w[PIN_P0+2][1] = pwm_a_en_i[1];
		req_w[PIN_P0+1][1] = pwm_a_en_i[2] && !pwm_a_ch3_route_bit_i;
		req_w[PIN_P0+0][1] = pwm_a_en_i[3];
		req_w[PIN_P0+4][0] = (adc_trigger_route_field_i == ADC_TRIG_RT_PIN);
		// j: uart then i2c when routed away from port s
		for (int i = 0; i < 2; i++)
		begin
			req_w[PIN_J0+i][1:0] = {i2c_en_i[1-i] && !i2c_route_bit_i, uart_a_en_i[1-i] && !uart_a_route_bit_i};
			out_w[PIN_J0+i][1]   = i2c_out_i[1-i];
			oe_w[PIN_J0+i][1]    = i2c_oe_i[1-i];
		end
		out_w[PIN_J0+1][0] = uart_a_out_i;
		oe_w[PIN_J0+1][0]  = uart_a_oe_i;
	end

	// ****************
	// per pin selection
	// ****************
	generate
		for (genvar p = 0; p < NUM_PINS; p++)
		begin : g_pin
			pin_prio_sel #(.SLOTS(NUM_SLOTS)) u_sel (
				.req_i     (req_w[p]),
				.out_i     (out_w[p]),
				.oe_i      (oe_w[p]),
				.grant_o   (gnt_w[p]),
				.pin_out_o (pin_out_w[p]),
				.pin_oe_o  (pin_oe_w[p])
			);
		end
	endgenerate

	nmi_gate u_nmi (
		.core_clk_i  (core_clk_i),
		.srst_i      (srst_i),
		.x_mask_i    (x_mask_i),
		.stop_wait_i (stop_wait_i),
		.pin_level_i (nonmaskable_interrupt_in_o),
		.armed_o     (nmi_armed_w),
		.wake_o      (nmi_wake_o)
	);
	assign nmi_enabled_o = nmi_armed_w;

	// ****************
	// pin drive, back to gpio inputs at reset
	// ****************
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			{port_j_pin_o, port_p_pin_o, port_s_pin_o}          <= {NUM_PINS{PIN_OUT_RST}};
			{port_j_pin_oe_o, port_p_pin_oe_o, port_s_pin_oe_o} <= {NUM_PINS{PIN_OE_RST}};
		end
		else
		begin
			{port_j_pin_o, port_p_pin_o, port_s_pin_o}          <= pin_out_w;
			{port_j_pin_oe_o, port_p_pin_oe_o, port_s_pin_oe_o} <= pin_oe_w;
		end
	end

	// ****************
	// function inputs
	// ****************
	logic       uart_a_rx_w;
	logic       uart_b_rx_w;
	logic [1:0] i2c_w;

	// a lane lives on at most one pin at a time, so and-ing the idle-high gated samples is safe
	assign uart_a_rx_w = samp(gnt_w[PIN_S0+0][1], pin_in_w[PIN_S0+0]) & samp(gnt_w[PIN_J0][0], pin_in_w[PIN_J0]);
	assign uart_b_rx_w = samp(gnt_w[PIN_S0+4][1], pin_in_w[PIN_S0+4]);
	assign i2c_w[0] = samp(gnt_w[PIN_S0+1][2], pin_in_w[PIN_S0+1]) & samp(gnt_w[PIN_J0+1][1], pin_in_w[PIN_J0+1]);
	assign i2c_w[1] = samp(gnt_w[PIN_S0+0][2], pin_in_w[PIN_S0+0]) & samp(gnt_w[PIN_J0][1], pin_in_w[PIN_J0]);

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			timer_a_in_o <= {4{IDLE_LVL}};
			sent_line_in_o <= IDLE_LVL;
			spi_a_in_o <= {4{IDLE_LVL}};
			spi_b_in_o <= {4{IDLE_LVL}};
			uart_a_in_o <= {2{IDLE_LVL}};
			uart_b_in_o <= {2{IDLE_LVL}};
			i2c_in_o <= {2{IDLE_LVL}};
			nonmaskable_interrupt_in_o <= IDLE_LVL;
			irq_in_o <= IDLE_LVL;
			can_receive_o <= IDLE_LVL;
			can_phy_transmit_in_o <= IDLE_LVL;
			adc_external_trigger_o <= 1'b0;
		end
		else
		begin
			timer_a_in_o[0] <= samp(gnt_w[PIN_S0+7][0], pin_in_w[PIN_S0+7]);
			timer_a_in_o[1] <= timer_a_cap1_route_bit_i ? samp(gnt_w[PIN_S0+6][0], pin_in_w[PIN_S0+6])
				: samp(gnt_w[PIN_S0+7][1], pin_in_w[PIN_S0+7]);
			timer_a_in_o[2] <= timer_a_cap2_route_bit_i ? samp(gnt_w[PIN_S0+5][0], pin_in_w[PIN_S0+5])
				: timer_a_cap2_alt_i;
			case (timer_a_cap3_route_field_i)
				CAP3_RT_UART_A: timer_a_in_o[3] <= uart_a_rx_w;
				CAP3_RT_UART_B: timer_a_in_o[3] <= uart_b_rx_w;
				default:        timer_a_in_o[3] <= samp(gnt_w[PIN_S0+4][0], pin_in_w[PIN_S0+4]);
			endcase
			sent_line_in_o <= samp(gnt_w[PIN_S0+7][2], pin_in_w[PIN_S0+7]);
			spi_b_in_o <= {samp(gnt_w[PIN_S0+4][2], pin_in_w[PIN_S0+4]), samp(gnt_w[PIN_S0+5][2], pin_in_w[PIN_S0+5]),
				samp(gnt_w[PIN_S0+6][1], pin_in_w[PIN_S0+6]), samp(gnt_w[PIN_S0+7][3], pin_in_w[PIN_S0+7])};
			spi_a_in_o <= {samp(gnt_w[PIN_S0+0][3], pin_in_w[PIN_S0+0]), samp(gnt_w[PIN_S0+1][3], pin_in_w[PIN_S0+1]),
				samp(gnt_w[PIN_S0+2][2], pin_in_w[PIN_S0+2]), samp(gnt_w[PIN_S0+3][2], pin_in_w[PIN_S0+3])};
			uart_a_in_o <= {uart_a_rx_w, samp(gnt_w[PIN_S0+1][1], pin_in_w[PIN_S0+1])
				& samp(gnt_w[PIN_J0+1][0], pin_in_w[PIN_J0+1])};
			uart_b_in_o <= {uart_b_rx_w, samp(gnt_w[PIN_S0+5][1], pin_in_w[PIN_S0+5])};
			i2c_in_o <= i2c_w;
			nonmaskable_interrupt_in_o <= samp(gnt_w[PIN_S0+3][0], pin_in_w[PIN_S0+3]);
			irq_in_o <= samp(gnt_w[PIN_S0+2][0], pin_in_w[PIN_S0+2]);
			can_receive_o <= samp(gnt_w[PIN_S0+2][1], pin_in_w[PIN_S0+2]);
			can_phy_transmit_in_o <= samp(gnt_w[PIN_S0+1][0], pin_in_w[PIN_S0+1]);
			adc_external_trigger_o <= gnt_w[PIN_P0+4][0] & pin_in_w[PIN_P0+4];
		end
	end

	// ****************
	// gpio read, key wakeup, over-current, high voltage inputs
	// ****************
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			port_s_data_o <= '0;
			port_p_data_o <= '0;
			port_j_data_o <= '0;
			port_s_key_wakeup_o <= '0;
			port_p_key_wakeup_o <= '0;
			port_p_oc_irq_o <= '0;
			port_l_input_o <= '0;
			port_l_key_wakeup_o <= '0;
			port_l_adc_link_o <= '0;
		end
		else
		begin
			port_s_data_o <= port_s_pin_i;
			port_p_data_o <= port_p_pin_i;
			port_j_data_o <= port_j_pin_i;
			for (int i = 0; i < 8; i++)
			begin
				port_s_key_wakeup_o[i] <= samp(gnt_w[PIN_S0+i][SLOT_GPIO], pin_in_w[PIN_S0+i]);
				port_p_key_wakeup_o[i] <= samp(gnt_w[PIN_P0+i][SLOT_GPIO], pin_in_w[PIN_P0+i]);
			end
			// flagged in pwm and gpio use alike
			port_p_oc_irq_o <= port_p_oc_sense_i & P_HC_MASK;
			port_l_input_o <= port_l_pin_i;
			port_l_key_wakeup_o <= port_l_pin_i;
			port_l_adc_link_o <= port_l_pin_i & port_l_adc_link_en_i;
		end
	end

	// ****************
	// checks
	// ****************
	AST_S7_TIMER_WINS: assert property (@(posedge core_clk_i) disable iff (srst_i)
		timer_a_en_i[0] |=> port_s_pin_o[7] == $past(timer_a_out_i[0]) && port_s_pin_oe_o[7] == $past(timer_a_oe_i[0]))
		else $error("s7 not driven by timer channel 0");
	AST_S6_COMPARE_STAYS: assert property (@(posedge core_clk_i) disable iff (srst_i)
		timer_a_en_i[1] |=> port_s_pin_o[6] == $past(timer_a_out_i[1]))
		else $error("s6 lost channel 1 compare");
	AST_CAP1_FROM_S7: assert property (@(posedge core_clk_i) disable iff (srst_i)
		timer_a_en_i[1] && !timer_a_cap1_route_bit_i && !timer_a_en_i[0]
		|=> timer_a_in_o[1] == $past(port_s_pin_i[7]))
		else $error("capture 1 not taken from s7");
	AST_S5_UART_B: assert property (@(posedge core_clk_i) disable iff (srst_i)
		!timer_a_en_i[2] && uart_b_en_i[0] && !uart_b_route_bit_i |=> port_s_pin_o[5] == $past(uart_b_out_i))
		else $error("s5 not driven by uart_b");
	AST_NMI_INPUT_ONLY: assert property (@(posedge core_clk_i) disable iff (srst_i)
		nmi_enabled_o |=> !port_s_pin_oe_o[3] ##1 !port_s_pin_oe_o[3])
		else $error("s3 driven while nmi armed");
	AST_IRQ_OUTRANKS_CAN: assert property (@(posedge core_clk_i) disable iff (srst_i)
		irq_en_i |=> irq_in_o == $past(port_s_pin_i[2]) && can_receive_o == IDLE_LVL)
		else $error("s2 priority broken");
	AST_P4_TRIGGER_INPUT: assert property (@(posedge core_clk_i) disable iff (srst_i)
		adc_trigger_route_field_i == ADC_TRIG_RT_PIN |=> !port_p_pin_oe_o[4])
		else $error("p4 driven while trigger routed");
	AST_OC_FLAG: assert property (@(posedge core_clk_i) disable iff (srst_i)
		1'b1 |=> port_p_oc_irq_o == ($past(port_p_oc_sense_i) & P_HC_MASK))
		else $error("over-current flag mismatch");
	AST_RESET_RELEASES_PINS: assert property (@(posedge core_clk_i)
		srst_i |=> port_s_pin_oe_o == 8'h00 && port_p_pin_oe_o == 8'h00 && port_j_pin_oe_o == 2'h0)
		else $error("pin driven after reset");
endmodule

// ---- rtl/pin_mux_pkg.sv ----
/*
 * constants shared by the pin function multiplexer and its helpers.
 * assumes a single core clock domain; routing field encodings are local.
 */
package pin_mux_pkg;
	// ****************
	// pin table shape
	// ****************
	localparam int NUM_PINS  = 18;
	localparam int NUM_SLOTS = 5;
	localparam int SLOT_GPIO = 4;
	localparam int PIN_S0    = 0;
	localparam int PIN_P0    = 8;
	localparam int PIN_J0    = 16;

	// ****************
	// levels and reset values
	// ****************
	localparam logic       IDLE_LVL    = 1'h1;
	localparam logic       PIN_OUT_RST = 1'h0;
	localparam logic       PIN_OE_RST  = 1'h0;
	localparam logic [7:0] P_HC_MASK   = 8'h75;

	// ****************
	// routing encodings
	// ****************
	localparam logic [2:0] CAN_RT_CAN    = 3'h1;
	localparam logic [2:0] CAN_RT_DIRECT = 3'h2;
	localparam logic [2:0] CAN_RT_PHY    = 3'h3;
	localparam logic [1:0] ADC_TRIG_RT_PIN = 2'h2;
	localparam logic [1:0] CAP3_RT_UART_A  = 2'h0;
	localparam logic [1:0] CAP3_RT_UART_B  = 2'h1;

	typedef enum logic [1:0] {
		NMI_MASKED = 2'b01,
		NMI_ARMED  = 2'b10
	} nmi_state_t;
endpackage

// ---- rtl/pin_prio_sel.sv ----
/*
 * fixed priority selector for one pin: slot 0 wins over higher slots.
 * assumes the caller registers the result; purely combinational.
 */
module pin_prio_sel
	import pin_mux_pkg::*;
#(
	parameter int SLOTS = pin_mux_pkg::NUM_SLOTS
)(
	// function requests, slot 0 highest
	input  wire logic [SLOTS-1:0] req_i,
	input  wire logic [SLOTS-1:0] out_i,
	input  wire logic [SLOTS-1:0] oe_i,
	// selection
	output logic      [SLOTS-1:0] grant_o,
	output logic                  pin_out_o,
	output logic                  pin_oe_o
);
	generate
		if (SLOTS < 2)
		begin : g_bad
			$error("pin_prio_sel needs at least two slots");
		end
	endgenerate

	always_comb
	begin
		logic found;
		found = 1'b0;
		grant_o = '0;
		for (int k = 0; k < SLOTS; k++)
		begin
			if (req_i[k] && !found)
			begin
				grant_o[k] = 1'b1;
				found = 1'b1;
			end
		end
	end

	// outranked slots neither drive nor enable the pin
	assign pin_out_o = |(grant_o & out_i);
	assign pin_oe_o  = |(grant_o & oe_i);
endmodule

// ---- rtl/nmi_gate.sv ----
/*
 * non-maskable interrupt pin lock and wakeup qualifier.
 * assumes x_mask_i is the processor mask bit, set out of reset.
 */
module nmi_gate
	import pin_mux_pkg::*;
(
	// clock and reset
	input  wire logic core_clk_i,
	input  wire logic srst_i,
	// processor state
	input  wire logic x_mask_i,
	input  wire logic stop_wait_i,
	// sampled pin, active low
	input  wire logic pin_level_i,
	// status
	output logic      armed_o,
	output logic      wake_o
);
	nmi_state_t state_r;
	logic       wake_r;

	// one-way lock: only a reset leaves the armed state
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			state_r <= NMI_MASKED;
		else
		begin
			case (state_r)
				NMI_MASKED: if (!x_mask_i) state_r <= NMI_ARMED;
				NMI_ARMED:  state_r <= NMI_ARMED;
				default:    state_r <= NMI_MASKED;
			endcase
		end
	end

	// no recovery from stop or wait while the mask is still set
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			wake_r <= 1'b0;
		else
			wake_r <= (state_r == NMI_ARMED) && stop_wait_i && !x_mask_i && !pin_level_i;
	end

	assign armed_o = (state_r == NMI_ARMED);
	assign wake_o  = wake_r;

	AST_NMI_LOCK_HOLDS: assert property (@(posedge core_clk_i) disable iff (srst_i)
		armed_o |=> armed_o [*8])
		else $error("nmi lock released without reset");
	AST_NMI_ARM_ON_CLEAR: assert property (@(posedge core_clk_i) disable iff (srst_i)
		!x_mask_i |=> armed_o)
		else $error("nmi not armed after mask cleared");
	AST_NMI_NO_WAKE_MASKED: assert property (@(posedge core_clk_i) disable iff (srst_i)
		x_mask_i |=> !wake_o)
		else $error("nmi wake with mask set");
endmodule

// ---- sim/pin_partner.sv ----
/*
 * package pin model for the pin function multiplexer bench.
 * assumes the bench sets the level that the outside world puts on each pin.
 */
module pin_wires
(
	// driven side
	input  wire logic [7:0] port_s_pin_o,
	input  wire logic [7:0] port_s_pin_oe_o,
	input  wire logic [7:0] port_p_pin_o,
	input  wire logic [7:0] port_p_pin_oe_o,
	input  wire logic [1:0] port_j_pin_o,
	input  wire logic [1:0] port_j_pin_oe_o,
	// outside levels
	input  wire logic [7:0] s_ext,
	input  wire logic [7:0] p_ext,
	input  wire logic [1:0] j_ext,
	input  wire logic [1:0] l_ext,
	// resolved pin levels
	output logic      [7:0] port_s_pin_i,
	output logic      [7:0] port_p_pin_i,
	output logic      [1:0] port_j_pin_i,
	output logic      [1:0] port_l_pin_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// driver wins where enabled, so contention never shows
	assign port_s_pin_i = (port_s_pin_o & port_s_pin_oe_o) | (s_ext & ~port_s_pin_oe_o);
	assign port_p_pin_i = (port_p_pin_o & port_p_pin_oe_o) | (p_ext & ~port_p_pin_oe_o);
	assign port_j_pin_i = (port_j_pin_o & port_j_pin_oe_o) | (j_ext & ~port_j_pin_oe_o);
	assign port_l_pin_i = l_ext;
endmodule

// ---- sim/port_s_p_j_l_pin_function_mux_bench.sv ----
/*
 * self-checking bench for pin_func_mux.
 * assumes pin_wires resolves the pins; nmi test runs last, it locks until reset.
 */
module port_s_p_j_l_pin_function_mux_bench;
	import pin_mux_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i = 1'h0, srst_i = 1'h1, x_mask_i = 1'h1;
	logic timer_a_cap1_route_bit_i = '0, timer_a_cap2_route_bit_i = '0, uart_a_route_bit_i = '0, uart_b_route_bit_i = '0;
	logic i2c_route_bit_i = '0, spi_a_route_bit_i = '0, pwm_a_ch7_route_bit_i = '0, pwm_a_ch3_route_bit_i = '0;
	logic timer_a_cap2_alt_i = '0, sent_line_en_i = '0, sent_line_out_i = '0, sent_line_oe_i = '0, stop_wait_i = '0;
	logic uart_a_out_i = '0, uart_a_oe_i = '0, uart_b_out_i = '0, uart_b_oe_i = '0, irq_en_i = '0, can_en_i = '0;
	logic can_transmit_i = '0, can_phy_direct_out_i = '0, can_phy_receive_out_i = '0;
	logic [1:0] timer_a_cap3_route_field_i = '0, adc_trigger_route_field_i = '0, uart_a_en_i = '0, uart_b_en_i = '0;
	logic [1:0] i2c_en_i = '0, i2c_out_i = '0, i2c_oe_i = '0, port_j_data_out_i = '0, port_j_data_oe_i = '0;
	logic [1:0] port_l_adc_link_en_i = '0, j_ext = '0, l_ext = '0;
	logic [2:0] can_route_field_i = '0;
	logic [3:0] timer_a_en_i = '0, timer_a_out_i = '0, timer_a_oe_i = '0, spi_a_en_i = '0, spi_a_out_i = '0;
	logic [3:0] spi_a_oe_i = '0, spi_b_en_i = '0, spi_b_out_i = '0, spi_b_oe_i = '0, pwm_a_en_i = '0, pwm_a_out_i = '0;
	logic [3:0] pwm_b_en_i = '0, pwm_b_out_i = '0;
	logic [7:0] port_s_data_out_i = '0, port_s_data_oe_i = '0, port_p_data_out_i = '0, port_p_data_oe_i = '0;
	logic [7:0] port_p_oc_sense_i = '0, s_ext = '0, p_ext = '0;
	logic [7:0] port_s_pin_i, port_s_pin_o, port_s_pin_oe_o, port_p_pin_i, port_p_pin_o, port_p_pin_oe_o;
	logic [7:0] port_s_data_o, port_s_key_wakeup_o, port_p_data_o, port_p_key_wakeup_o, port_p_oc_irq_o;
	logic [1:0] port_j_pin_i, port_j_pin_o, port_j_pin_oe_o, port_l_pin_i, uart_a_in_o, uart_b_in_o, i2c_in_o;
	logic [1:0] port_j_data_o, port_l_input_o, port_l_key_wakeup_o, port_l_adc_link_o;
	logic [3:0] timer_a_in_o, spi_a_in_o, spi_b_in_o;
	logic sent_line_in_o, nonmaskable_interrupt_in_o, nmi_enabled_o, nmi_wake_o, irq_in_o, can_receive_o;
	logic can_phy_transmit_in_o, adc_external_trigger_o;
	int n_mismatch = 0, comparisons = 0, cyc = 0;

	pin_func_mux dut_u (.*);
	pin_wires pins_u (.*);

	initial
	begin
		forever #2 core_clk_i = ~core_clk_i;
	end

	// ****************
	// shared helpers
	// ****************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic go(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// hang guard: whole run is about 55 cycles
	always @(posedge core_clk_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_mismatch++;
			give_verdict();
		end
	end

	// ****************
	// scenarios
	// ****************
	task automatic t_reset();
		chk(port_s_pin_oe_o, 8'h00);
		chk(port_p_pin_oe_o, 8'h00);
		chk(timer_a_in_o, 8'h0B);
		chk(nmi_enabled_o, 8'h00);
		chk(port_s_key_wakeup_o, 8'h00);
		chk(spi_a_in_o, 8'h0F);
		chk({irq_in_o, can_receive_o, can_phy_transmit_in_o, nonmaskable_interrupt_in_o}, 8'h0F);
		$display("reset test done");
	endtask

	task automatic t_port_s_high();
		@(posedge core_clk_i);
		{sent_line_en_i, sent_line_oe_i, sent_line_out_i} <= 3'h6;
		uart_b_en_i <= 2'h3;
		{uart_b_out_i, uart_b_oe_i} <= 2'h3;
		{timer_a_en_i, timer_a_out_i, timer_a_oe_i} <= {4'hD, 4'h1, 4'h5};
		go(2);
		chk(port_s_pin_o[7], 8'h01);
		chk(sent_line_in_o, 8'h01);
		chk(port_s_pin_o[5], 8'h00);
		chk(uart_b_in_o, 8'h03);
		@(posedge core_clk_i);
		timer_a_en_i <= 4'h0;
		go(2);
		chk({port_s_pin_oe_o[7], port_s_pin_o[7]}, 8'h02);
		chk(port_s_pin_o[5], 8'h01);
		chk(uart_b_in_o[1], 8'h00);
		@(posedge core_clk_i);
		{sent_line_en_i, uart_b_en_i} <= 3'h0;
		$display("port s high test done");
	endtask

	task automatic t_serial();
		@(posedge core_clk_i);
		{uart_a_en_i, uart_a_out_i, uart_a_oe_i} <= 4'h7;
		{i2c_en_i, i2c_out_i, i2c_oe_i} <= 6'h11;
		go(2);
		chk(port_j_pin_o[1], 8'h01);
		@(posedge core_clk_i);
		uart_a_en_i <= 2'h0;
		go(2);
		chk(port_j_pin_o[1], 8'h00);
		chk(i2c_in_o, 8'h02);
		@(posedge core_clk_i);
		{uart_a_en_i, uart_a_route_bit_i} <= 3'h3;
		go(2);
		chk(port_s_pin_o[1], 8'h01);
		@(posedge core_clk_i);
		can_route_field_i <= CAN_RT_PHY;
		go(2);
		chk(port_s_pin_oe_o[1], 8'h00);
		chk(can_phy_transmit_in_o, 8'h00);
		chk(uart_a_in_o[0], 8'h01);
		@(posedge core_clk_i);
		{uart_a_en_i, i2c_en_i, can_route_field_i} <= 7'h0;
		$display("serial test done");
	endtask

	task automatic t_port_p_l();
		@(posedge core_clk_i);
		{pwm_b_en_i, pwm_b_out_i, port_p_oc_sense_i} <= {4'h8, 4'h8, 8'hFF};
		{l_ext, port_l_adc_link_en_i, p_ext} <= {2'h3, 2'h1, 8'h10};
		go(2);
		chk({port_p_pin_oe_o[4], port_p_pin_o[4]}, 8'h03);
		chk(port_p_oc_irq_o, 8'h75);
		chk({port_l_input_o, port_l_adc_link_o}, 8'h0D);
		chk({port_l_key_wakeup_o, port_j_data_o}, 8'h0C);
		@(posedge core_clk_i);
		adc_trigger_route_field_i <= ADC_TRIG_RT_PIN;
		go(2);
		chk({port_p_pin_oe_o[4], adc_external_trigger_o}, 8'h01);
		@(posedge core_clk_i);
		{adc_trigger_route_field_i, pwm_b_en_i} <= 6'h0;
		$display("port p and l test done");
	endtask

	task automatic t_nmi();
		@(posedge core_clk_i);
		{stop_wait_i, port_s_data_oe_i} <= {1'h1, 8'h08};
		go(3);
		chk({port_s_pin_oe_o[3], nmi_wake_o}, 8'h02);
		@(posedge core_clk_i);
		x_mask_i <= 1'h0;
		go(3);
		chk({nmi_enabled_o, port_s_pin_oe_o[3], nmi_wake_o}, 8'h05);
		@(posedge core_clk_i);
		x_mask_i <= 1'h1;
		go(3);
		chk({nmi_enabled_o, port_s_pin_oe_o[3], nmi_wake_o}, 8'h04);
		@(posedge core_clk_i);
		srst_i <= 1'h1;
		go(2);
		chk({nmi_enabled_o, port_s_pin_oe_o[3]}, 8'h00);
		$display("nmi test done");
	endtask

	initial
	begin
		repeat (12) @(posedge core_clk_i);
		srst_i <= 1'h0;
		go(1);
		t_reset();
		t_port_s_high();
		t_serial();
		t_port_p_l();
		t_nmi();
		give_verdict();
	end
endmodule
